// ---- logic/flow_defines.svh ----
// Offsets, field positions and the control reset value of the list flow control block
`ifndef FLOW_DEFINES_SVH
`define FLOW_DEFINES_SVH
// ========================================
// Register byte offsets
`define OFS_CTRL 8'h00
`define OFS_FLOW 8'h04
`define OFS_ERR 8'h08
`define OFS_CONV 8'h0C
`define OFS_IMD 8'h10
`define OFS_EOL 8'h14
`define OFS_IDX 8'h18
// ========================================
// Control register fields
`define CTRL_ENABLE 0
`define CTRL_TRIGGER_REQUEST_MODE 1
`define CTRL_CMD_BMOD 2
`define CTRL_RES_BMOD 3
`define CTRL_ACC_LO 4
`define CTRL_ACC_HI 5
`define CTRL_AUTO_RST 6
`define CTRL_WAIT_STOP 7
`define CTRL_RESET 8'h30
// ========================================
// Flow request bits
`define REQ_ABORT 0
`define REQ_TRIGGER_REQUEST 1
`define REQ_RESTART 2
`define REQ_LOAD_OK 3
// ========================================
// Error and event flag bits
`define ERR_ABORT_DONE 0
`define ERR_RESTART 1
`define ERR_LOAD_OK 2
`define ERR_RESTART_REQ 3
// ========================================
// Status bits inside the error register
`define STAT_BUSY 8
`define STAT_CMD_SEL 9
`define STAT_RES_SEL 10
`endif

// ---- logic/flow_pkg.sv ----
// Types shared by the list flow control block
package flow_pkg;
  // ========================================
  // Conversion sequencing states
  typedef enum logic [2:0] {st_off, st_idle, st_arm, st_load, st_conv, st_abort} flow_state_type;
  // ========================================
  // Report from the converter when a command finished and its result is stored
  typedef struct packed {
    logic end_list;
    logic wrap_auto;
    logic end_seq;
    logic [3:0] flag_num;
  } conv_report_type;
  // ========================================
  // Result information: which lists and how far the result list was filled
  typedef struct packed {
    logic cmd_sel;
    logic res_sel;
    logic [7:0] index;
  } result_info_type;
endpackage

// ---- logic/sticky_flags.sv ----
// Sticky flag bank: hardware sets, software clears, set wins over clear
`timescale 1ns/10ps
`default_nettype none
module sticky_flags #(
  parameter int W = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [W-1:0] set_i,
  input wire logic [W-1:0] clr_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] flags_ff;
  // ========================================
  // Flag storage
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      flags_ff <= '0;
    else if (ce_i)
      flags_ff <= (flags_ff & ~clr_i) | set_i;
  end
  assign q_o = flags_ff;
endmodule
`default_nettype wire

// ---- logic/index_counter.sv ----
// List index counter: cleared on restart, advanced per command or result
`timescale 1ns/10ps
`default_nettype none
module index_counter (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic clr_i,
  input wire logic inc_i,
  output logic [7:0] q_o
);
  logic [7:0] count_ff;
  // ========================================
  // Counter, clear has priority
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      count_ff <= 8'h00;
    else if (ce_i)
    begin
      if (clr_i)
        count_ff <= 8'h00;
      else if (inc_i)
        count_ff <= count_ff + 8'h01;
    end
  end
  assign q_o = count_ff;
endmodule
`default_nettype wire

// ---- logic/list_flow_control.sv ----
// List flow control of the converter with a classic Wishbone register slave
//
// Notes on behaviour
// - With both lists double buffered, every list end or abort swaps results.
// - At list end the command list swaps only via load-ok with restart.
// - Result info registers update whenever a conversion or end flag sets.
// - After last command stored, set end flag and update end info.
// - Two-bit field selects bus, internal interface, or both as request source.
// - Trigger and restart modes; abort, trigger, restart, load-ok request bits.
// - Load-ok with restart then trigger starts from the second list.
// - Abort stops any sequence; its bit clears once aborted and idle.
// - After abort, restart; restart bit clears, then trigger runs from top.
// - In trigger mode an idle restart alone restarts, trigger made automatically.
// - Restart with abort: abort then restart; restart mode raises neither error.
// - Restart with abort in trigger mode raises no restart error.
// - Restart, load-ok, abort together: abort, restart with swap, same suppression.
// - Lone restart while busy starts automatic abort and sets request error.
// - On swap restart clears restart and load-ok, then runs the new list.
// - Trigger mode restart with load-ok runs the new list, auto trigger.
// - Trigger mode wrapping list runs continuously after one restart.
// - Auto restart enabled resumes conversion in trigger mode on leaving stop or wait-stop.
// - Restart clears both indices, loads first command, clears restart, load-ok.
// - After list end: trigger mode waits for trigger unless wrap_auto, restart mode idles.
`timescale 1ns/10ps
`default_nettype none
`include "flow_defines.svh"
module list_flow_control (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [3:0] ifc_req_i,
  input wire logic conv_done_i,
  input wire flow_pkg::conv_report_type conv_report_i,
  input wire logic conv_idle_i,
  input wire logic stop_i,
  input wire logic wait_i,
  output logic conv_start_o,
  output logic conv_abort_o,
  output logic [7:0] command_index_o,
  output logic [7:0] result_index_o,
  output logic cmd_sel_o,
  output logic res_sel_o
);
  import flow_pkg::*;

  // ========================================
  // Declarations
  flow_state_type state_ff, nxt_state;
  logic [7:0] ctrl_ff;
  logic [3:0] req_ff;
  logic ack_ff, start_ff, cmd_sel_ff, res_sel_ff, lp_ff;
  logic [31:0] rd_ff, rd_mux;
  result_info_type imd_info_ff, eol_info_ff, cur_info;
  logic [3:0] bus_req, ifc_req, new_req, err_q, err_set, err_clr;
  logic [15:0] conv_q, conv_set, conv_clr, flag_onehot;
  logic bus_acc, wr_ctrl, wr_flow, wr_err, wr_conv;
  logic new_sequence_abort_request, new_restart_request, new_load_ok_request, new_trigger_request, auto_abort, busy, trigger_request_mode;
  logic lp_now, lp_exit, res_mode, cmd_mode, list_end, abort_done, idx_clr, swap_cmd;
  logic [7:0] cmd_idx, res_idx;

  // ========================================
  // Wishbone decode, one access per ack
  assign bus_acc = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_ctrl = bus_acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_CTRL);
  assign wr_flow = bus_acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_FLOW);
  assign wr_err = bus_acc & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_ERR);
  assign wr_conv = bus_acc & wb_we_i & (wb_adr_i == `OFS_CONV);
  assign trigger_request_mode = ctrl_ff[`CTRL_TRIGGER_REQUEST_MODE];
  assign cmd_mode = ctrl_ff[`CTRL_CMD_BMOD];
  assign res_mode = ctrl_ff[`CTRL_RES_BMOD];

  // Request sources gated by the access select field
  assign bus_req = (wr_flow && ctrl_ff[`CTRL_ACC_LO]) ? wb_dat_i[3:0] : 4'h0;
  assign ifc_req = ctrl_ff[`CTRL_ACC_HI] ? ifc_req_i : 4'h0;
  assign new_req = bus_req | ifc_req;

  // Low power: stop, or wait when wait-stop is enabled
  assign lp_now = stop_i | (wait_i & ctrl_ff[`CTRL_WAIT_STOP]);
  assign lp_exit = lp_ff & ~lp_now & ctrl_ff[`CTRL_AUTO_RST];

  assign new_sequence_abort_request = new_req[`REQ_ABORT];
  assign new_restart_request = new_req[`REQ_RESTART] | lp_exit;
  assign new_load_ok_request = new_req[`REQ_LOAD_OK];
  assign new_trigger_request = new_req[`REQ_TRIGGER_REQUEST];
  assign busy = (state_ff == st_conv) || (state_ff == st_abort);
  // Lone restart on a busy converter turns into an abort
  assign auto_abort = new_restart_request & ~new_sequence_abort_request & ~req_ff[`REQ_ABORT] & busy;

  // ========================================
  // Sequencing events
  assign list_end = (state_ff == st_conv) & ~req_ff[`REQ_ABORT] & conv_done_i & conv_report_i.end_list;
  assign abort_done = (state_ff == st_abort) & conv_idle_i;
  assign idx_clr = (state_ff == st_load) | list_end | abort_done;
  assign swap_cmd = (state_ff == st_load) & req_ff[`REQ_LOAD_OK] & cmd_mode;

  // ========================================
  // Control register and low power history
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_ff <= `CTRL_RESET;
      lp_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      lp_ff <= lp_now;
      if (wr_ctrl)
        ctrl_ff <= wb_dat_i[7:0];
    end
  end

  // ========================================
  // Flow request bits, cleared by the block when the action completes
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      req_ff <= 4'h0;
    else if (ce_i)
    begin
      if (abort_done)
        req_ff[`REQ_ABORT] <= 1'b0;
      else if (new_sequence_abort_request | auto_abort)
        req_ff[`REQ_ABORT] <= 1'b1;
      if (state_ff == st_load)
      begin
        req_ff[`REQ_RESTART] <= 1'b0;
        req_ff[`REQ_LOAD_OK] <= 1'b0;
      end
      else
      begin
        if (new_restart_request)
          req_ff[`REQ_RESTART] <= 1'b1;
        if (new_load_ok_request)
          req_ff[`REQ_LOAD_OK] <= 1'b1;
      end
      // Triggers count only while armed
      if (state_ff == st_arm)
        req_ff[`REQ_TRIGGER_REQUEST] <= new_trigger_request & ~req_ff[`REQ_TRIGGER_REQUEST];
      else
        req_ff[`REQ_TRIGGER_REQUEST] <= 1'b0;
    end
  end

  // ========================================
  // Conversion sequencer
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      st_off:
        nxt_state = st_idle;
      st_idle, st_arm:
        if (req_ff[`REQ_ABORT])
          nxt_state = st_abort;
        else if (req_ff[`REQ_RESTART])
          nxt_state = st_load;
        else if (state_ff == st_arm && req_ff[`REQ_TRIGGER_REQUEST])
          nxt_state = st_conv;
      st_load:
        nxt_state = trigger_request_mode ? st_conv : st_arm;
      st_conv:
        if (req_ff[`REQ_ABORT])
          nxt_state = st_abort;
        else if (conv_done_i && conv_report_i.end_list)
        begin
          if (!trigger_request_mode)
            nxt_state = st_idle;
          else if (!conv_report_i.wrap_auto)
            nxt_state = st_arm;
        end
        else if (conv_done_i && conv_report_i.end_seq)
          nxt_state = st_arm;
      st_abort:
        if (conv_idle_i)
          nxt_state = st_idle;
      default:
        nxt_state = st_off;
    endcase
    if (!ctrl_ff[`CTRL_ENABLE] || lp_now)
      nxt_state = st_off;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      state_ff <= st_off;
    else if (ce_i)
      state_ff <= nxt_state;
  end

  // ========================================
  // Start pulse: first command after trigger, next command, or auto wrap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      start_ff <= 1'b0;
    else if (ce_i)
    begin
      if (nxt_state != st_conv)
        start_ff <= 1'b0;
      else if (state_ff != st_conv)
        start_ff <= 1'b1;
      else
        start_ff <= conv_done_i;
    end
  end

  // ========================================
  // List buffer selects, toggled on each swap
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      cmd_sel_ff <= 1'b0;
      res_sel_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      if (swap_cmd)
        cmd_sel_ff <= ~cmd_sel_ff;
      if (!cmd_mode)
        cmd_sel_ff <= 1'b0;
      if ((list_end | abort_done) & res_mode)
        res_sel_ff <= ~res_sel_ff;
      if (!res_mode)
        res_sel_ff <= 1'b0;
    end
  end

  // ========================================
  // Command and result indices
  index_counter cmd_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(idx_clr),
    .inc_i(state_ff == st_conv && conv_done_i),
    .q_o(cmd_idx)
  );

  index_counter res_counter (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .clr_i(idx_clr),
    .inc_i(state_ff == st_conv && conv_done_i),
    .q_o(res_idx)
  );

  // ========================================
  // Conversion flags: bit 0 is the end flag, 15..1 numbered flags
  always_comb
  begin
    flag_onehot = 16'h0000;
    flag_onehot[conv_report_i.flag_num] = 1'b1;
    conv_set = 16'h0000;
    if (state_ff == st_conv && !req_ff[`REQ_ABORT] && conv_done_i)
      conv_set = {flag_onehot[15:1], conv_report_i.end_list};
  end
  assign conv_clr = wr_conv ? {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                               wb_sel_i[0] ? wb_dat_i[7:0] : 8'h00} : 16'h0000;

  sticky_flags #(.W(16)) conv_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(conv_set),
    .clr_i(conv_clr),
    .q_o(conv_q)
  );

  // ========================================
  // Error flags with suppression for combined requests
  always_comb
  begin
    err_set = 4'h0;
    err_set[`ERR_ABORT_DONE] = abort_done;
    err_set[`ERR_RESTART] = new_restart_request & req_ff[`REQ_RESTART] & ~new_sequence_abort_request;
    err_set[`ERR_LOAD_OK] = new_load_ok_request & (~new_restart_request | req_ff[`REQ_LOAD_OK])
                            & ~(new_sequence_abort_request & new_restart_request & ~trigger_request_mode);
    err_set[`ERR_RESTART_REQ] = auto_abort;
  end
  assign err_clr = wr_err ? wb_dat_i[3:0] : 4'h0;

  sticky_flags #(.W(4)) err_flags (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .set_i(err_set),
    .clr_i(err_clr),
    .q_o(err_q)
  );

  // ========================================
  // Result information registers
  assign cur_info = '{cmd_sel: cmd_sel_ff, res_sel: res_sel_ff, index: res_idx + 8'h01};
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      imd_info_ff <= '0;
      eol_info_ff <= '0;
    end
    else if (ce_i)
    begin
      if (conv_set != 16'h0000)
        imd_info_ff <= cur_info;
      if (conv_set[0])
        eol_info_ff <= cur_info;
    end
  end

  // ========================================
  // Read mux; unmapped addresses read zero and still acknowledge
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      `OFS_CTRL: rd_mux = {24'h00_0000, ctrl_ff};
      `OFS_FLOW: rd_mux = {28'h000_0000, req_ff};
      `OFS_ERR: rd_mux = {21'h0_0000, res_sel_ff, cmd_sel_ff, busy, 4'h0, err_q};
      `OFS_CONV: rd_mux = {16'h0000, conv_q};
      `OFS_IMD: rd_mux = {22'h0_0000, imd_info_ff};
      `OFS_EOL: rd_mux = {22'h0_0000, eol_info_ff};
      `OFS_IDX: rd_mux = {8'h00, res_idx, 8'h00, cmd_idx};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Registered ack and read data, one wait state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff <= 1'b0;
      rd_ff <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      ack_ff <= bus_acc;
      if (bus_acc)
        rd_ff <= rd_mux;
    end
  end

  // ========================================
  // Outputs
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rd_ff;
  assign conv_start_o = start_ff;
  assign conv_abort_o = (state_ff == st_abort);
  assign command_index_o = cmd_idx;
  assign result_index_o = res_idx;
  assign cmd_sel_o = cmd_sel_ff;
  assign res_sel_o = res_sel_ff;

  // ========================================
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i || !ce_i);

  sequence load_s;
    state_ff == st_load && ctrl_ff[`CTRL_ENABLE] && !lp_now;
  endsequence

  abort_clear_a: assert property (abort_done |=> !req_ff[`REQ_ABORT])
    else $error("abort bit not cleared after abort finished");
  load_clear_a: assert property (load_s |=> cmd_idx == 8'h00 && !req_ff[`REQ_RESTART])
    else $error("restart did not clear index and restart bit");
  cmd_swap_a: assert property (swap_cmd |=> cmd_sel_ff != $past(cmd_sel_ff))
    else $error("command list not swapped on restart with load-ok");
  res_swap_a: assert property (list_end && res_mode |=> res_sel_ff != $past(res_sel_ff))
    else $error("result list not swapped at list end");
  auto_trigger_request_a: assert property (load_s and trigger_request_mode |=> conv_start_o)
    else $error("trigger mode restart did not start conversion");
  auto_abort_a: assert property (auto_abort |=> req_ff[`REQ_ABORT] && err_q[`ERR_RESTART_REQ])
    else $error("busy restart did not abort and flag");
  pair_noerr_a: assert property (new_restart_request && new_sequence_abort_request && !err_q[`ERR_RESTART] |=> !err_q[`ERR_RESTART])
    else $error("restart error raised on combined abort and restart");
  eol_flag_a: assert property (list_end |=> conv_q[0] && eol_info_ff == $past(cur_info))
    else $error("end flag or end info not updated");
  lp_resume_a: assert property (lp_exit && !auto_abort |=> req_ff[`REQ_RESTART])
    else $error("no restart after leaving low power");
endmodule
`default_nettype wire

// ---- test/conv_model.sv ----
// Behavioural converter on the far side of the list flow control block
`timescale 1ns/10ps
`default_nettype none
module conv_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [7:0] cmd_idx_i,
  input wire logic [7:0] len_i,
  input wire logic [7:0] dly_i,
  input wire logic wrap_i,
  output logic done_o,
  output flow_pkg::conv_report_type report_o,
  output logic idle_o
);
  import flow_pkg::*;
  logic [7:0] cnt_ff;
  logic [7:0] idx_ff;
  logic busy_ff;
  logic stop_ff;
  // ========================================
  // One result per start; an abort drains in four cycles with no result
  always_ff @(posedge clk_i)
  begin
    done_o <= 1'b0;
    if (rst_i)
    begin
      busy_ff <= 1'b0;
      stop_ff <= 1'b0;
      cnt_ff <= 8'h00;
      idx_ff <= 8'h00;
    end
    else if (abort_i && busy_ff && !stop_ff)
    begin
      stop_ff <= 1'b1;
      cnt_ff <= 8'h03;
    end
    else if (start_i && !busy_ff)
    begin
      busy_ff <= 1'b1;
      cnt_ff <= dly_i;
      idx_ff <= cmd_idx_i;
    end
    else if (busy_ff && cnt_ff != 8'h00)
      cnt_ff <= cnt_ff - 8'h01;
    else if (busy_ff)
    begin
      busy_ff <= 1'b0;
      stop_ff <= 1'b0;
      done_o <= !stop_ff;
    end
  end
  // Idle only when nothing is in flight, so an abort is never seen early
  assign idle_o = !busy_ff;
  // Report of the finished command; the last entry of the list ends it
  assign report_o = '{end_list: (idx_ff == len_i - 8'h01), wrap_auto: wrap_i, end_seq: 1'b0,
    flag_num: idx_ff[3:0] + 4'h1};
endmodule
`default_nettype wire

// ---- test/list_flow_control_tb_top.sv ----
// Testbench of the list flow control block driven over Wishbone
`timescale 1ns/10ps
`default_nettype none
module list_flow_control_tb_top;
  import flow_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic ack;
  logic [3:0] ifc_req = 4'h0;
  logic stop = 1'b0;
  logic [7:0] len = 8'h02;
  logic [7:0] dly = 8'h04;
  logic wrap = 1'b0;
  logic done, idle, start, abort, cmd_sel, res_sel;
  conv_report_type rep;
  logic [7:0] cidx;
  logic [7:0] ridx;
  logic wt = 1'b0;
  int err_count = 0;
  int samples_checked = 0;
  int starts = 0;
  int cycles = 0;
  int s0;
  logic abort_seen = 1'b0;
  logic [31:0] d;
  logic exp_cmd = 1'b0;
  always #10 clk_i = ~clk_i;
  list_flow_control dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .ifc_req_i(ifc_req), .conv_done_i(done),
    .conv_report_i(rep), .conv_idle_i(idle), .stop_i(stop), .wait_i(wt),
    .conv_start_o(start), .conv_abort_o(abort), .command_index_o(cidx),
    .result_index_o(ridx), .cmd_sel_o(cmd_sel), .res_sel_o(res_sel));
  conv_model partner (.clk_i(clk_i), .rst_i(rst_i), .start_i(start), .abort_i(abort),
    .cmd_idx_i(cidx), .len_i(len), .dly_i(dly), .wrap_i(wrap), .done_o(done),
    .report_o(rep), .idle_o(idle));
  // ========================================
  // Start pulses, abort activity and the hang limit
  always @(posedge clk_i)
  begin
    cycles++;
    if (start === 1'b1) starts++;
    if (abort === 1'b1) abort_seen = 1'b1;
    if (cycles > 20000)
    begin
      err_count++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    if (err_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // One classic cycle; held until ack is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] v);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= v;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 50);
    if (n >= 50) err_count++;
    d = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      $display("[ERR] %s expected %h seen %h", nm, e, g);
      err_count++;
    end
  endtask
  // Poll a register until the masked bits equal the wanted value
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, a, 32'h0);
      n++;
    end
    while ((d & m) !== v && n < 100);
    chk("poll", v, d & m);
  endtask
  task automatic idle_cycles(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Start a slow list and abort it with the given request bits
  task automatic abort_busy(input logic [31:0] code);
    dly <= 8'h28;
    poll(8'h04, 32'h0000000F, 32'h0);
    chk("cmd sel", 32'(exp_cmd), 32'(cmd_sel));
    xfer(1'b1, 8'h04, 32'h4);
    poll(8'h04, 32'h4, 32'h0);
    xfer(1'b1, 8'h04, 32'h2);
    poll(8'h08, 32'h100, 32'h100);
    xfer(1'b1, 8'h08, 32'hF);
    abort_seen = 1'b0;
    xfer(1'b1, 8'h04, code);
    poll(8'h04, 32'hD, 32'h0);
    xfer(1'b0, 8'h08, 32'h0);
  endtask
  // ========================================
  // Main sequence
  initial
  begin
    idle_cycles(4);
    rst_i <= 1'b0;
    xfer(1'b0, 8'h00, 32'h0);
    chk("ctrl reset", 32'h30, d);
    xfer(1'b1, 8'h40, 32'hFF);
    xfer(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, d);
    // Restart mode, both lists double buffered, bus requests
    xfer(1'b1, 8'h00, 32'h1D);
    xfer(1'b1, 8'h04, 32'h4);
    poll(8'h04, 32'h4, 32'h0);
    xfer(1'b0, 8'h18, 32'h0);
    chk("index", 32'h0, d);
    chk("res index port", 32'h0, 32'(ridx));
    xfer(1'b1, 8'h04, 32'h2);
    poll(8'h0C, 32'h1, 32'h1);
    xfer(1'b0, 8'h0C, 32'h0);
    chk("flags", 32'h7, d);
    xfer(1'b0, 8'h14, 32'h0);
    chk("end info", 32'h2, d & 32'h2FF);
    xfer(1'b0, 8'h10, 32'h0);
    chk("imd info", 32'h2, d & 32'hFF);
    chk("res sel", 32'h1, 32'(res_sel));
    chk("cmd sel", 32'h0, 32'(cmd_sel));
    s0 = starts;
    idle_cycles(30);
    chk("idle", s0, starts);
    xfer(1'b1, 8'h0C, 32'hFFFF);
    // Swap to the second command list
    xfer(1'b1, 8'h04, 32'hC);
    poll(8'h04, 32'hC, 32'h0);
    chk("swap sel", 32'h1, 32'(cmd_sel));
    xfer(1'b1, 8'h04, 32'h2);
    poll(8'h0C, 32'h1, 32'h1);
    chk("res back", 32'h0, 32'(res_sel));
    exp_cmd = 1'b1;
    // Abort with restart, then with restart and load-ok, then a lone restart while busy
    abort_busy(32'h5);
    chk("abort err", 32'h1, d & 32'h7);
    chk("abort seen", 32'h1, 32'(abort_seen));
    abort_busy(32'hD);
    exp_cmd = 1'b0;
    chk("triple err", 32'h1, d & 32'h7);
    chk("triple sel", 32'h0, 32'(cmd_sel));
    abort_busy(32'h4);
    chk("busy restart", 32'h8, d & 32'h8);
    chk("auto abort", 32'h1, 32'(abort_seen));
    // Trigger mode: restart alone runs the list, then waits
    xfer(1'b1, 8'h00, 32'h1F);
    dly <= 8'h04;
    idle_cycles(100);
    s0 = starts;
    xfer(1'b1, 8'h04, 32'h4);
    idle_cycles(60);
    chk("auto trigger_request", s0 + 2, starts);
    xfer(1'b1, 8'h04, 32'hC);
    idle_cycles(60);
    chk("trigger_request swap", 32'h1, 32'(cmd_sel));
    chk("trigger_request swap run", s0 + 4, starts);
    exp_cmd = 1'b1;
    abort_busy(32'h5);
    chk("trigger_request abort", 32'h0, d & 32'h2);
    dly <= 8'h04;
    idle_cycles(150);
    // Request source selection
    s0 = starts;
    @(posedge clk_i) ifc_req <= 4'h4;
    @(posedge clk_i) ifc_req <= 4'h0;
    idle_cycles(20);
    chk("bus only", s0, starts);
    xfer(1'b1, 8'h00, 32'h2F);
    xfer(1'b1, 8'h04, 32'h4);
    idle_cycles(20);
    chk("ifc only", s0, starts);
    @(posedge clk_i) ifc_req <= 4'h4;
    @(posedge clk_i) ifc_req <= 4'h0;
    idle_cycles(20);
    chk("ifc start", 32'h1, 32'(starts > s0));
    idle_cycles(60);
    // Continuous wrapping list, then low power with auto restart
    wrap <= 1'b1;
    xfer(1'b1, 8'h00, 32'h53);
    s0 = starts;
    xfer(1'b1, 8'h04, 32'h4);
    idle_cycles(100);
    chk("continuous", 32'h1, 32'(starts >= s0 + 8));
    @(posedge clk_i) stop <= 1'b1;
    idle_cycles(10);
    s0 = starts;
    idle_cycles(10);
    chk("stop halt", s0, starts);
    @(posedge clk_i) stop <= 1'b0;
    idle_cycles(60);
    chk("resume", 32'h1, 32'(starts > s0));
    // Wait with wait-stop set halts too, with both request sources open
    xfer(1'b1, 8'h00, 32'hF3);
    @(posedge clk_i) wt <= 1'b1;
    idle_cycles(10);
    s0 = starts;
    idle_cycles(10);
    chk("wait halt", s0, starts);
    @(posedge clk_i) wt <= 1'b0;
    idle_cycles(60);
    chk("wait resume", 32'h1, 32'(starts > s0));
    tally_and_finish();
  end
endmodule
`default_nettype wire
